// file: verilog/qsfp_pkg.sv
// Constants for the four-channel high-side switch fault protection block.
// Assumes a 100 MHz system clock; analog comparators arrive as pin levels.
// Operation
// RL1 - Overheat while commanded on latches that output off and fault pin low.
// RL2 - Overheat latch releases when cleared plus autoretry, off-on toggle or POR.
// RL3 - Overheat while commanded off holds fault pin low only while hot.
// RL4 - Overheat sets the channel temperature status bit; a read clears it.
// RL5 - Overcurrent follows eight-level profile: gas lamp default, 55 W, 28 W.
// RL6 - Turn-on rising edge or autoretry restarts the inrush profile from cold.
// RL7 - Two-bit slope sets step speed; skip bit drops the first high step.
// RL8 - Steady state uses second low level; two bits pick first, third, fourth.
// RL9 - Reaching active level latches output off and fault pin, same release.
// RL10 - Overcurrent status bits clear after a status read.
// RL11 - With PWM, cooling and lamp bits, first step follows preceding off time.
// RL12 - Severe short latches off, sets status; only toggle or POR release it. Code also releases it on a mode change.
// RL13 - Overvoltage shuts all outputs until hysteresis clears; status bit set.
// RL14 - Overvoltage disabled: outputs stay, warning clears on read once gone.
// RL15 - In fail-safe, overvoltage protection follows the reset pin level.
// RL16 - Undervoltage turns outputs off, fault pin low, sets status, keeps state.
// RL17 - Recovery with outputs off releases fault pin; status waits for read.
// RL18 - Recovery with output on keeps fault pin low until a release event.
// RL19 - Extended mode keeps latches, reports new overheat, leaves outputs as is.
// RL20 - Logic supply loss with battery good, or both below POR, clear faults.
// RL21 - Retry is requested on channel overcurrent, overheat or undervoltage.
// RL22 - Retry after one period, at most 16 times, defaults; mode change resets.
// RL23 - Release uses turn-on command: direct input when allowed, or on bit.
// RL24 - After all retries, output stays off until toggle, mode change or POR.
package qsfp_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_LVL = 8;
  localparam int CNT_W = 24;
  localparam int CLK_MHZ = 100;

  // Level indices into the per-channel comparator vector, highest first
  localparam logic [2:0] LVL_HIGH1 = 3'h0;
  localparam logic [2:0] LVL_INRUSH_LAST = 3'h3;
  localparam logic [2:0] LVL_STEADY1 = 3'h4;
  localparam logic [2:0] LVL_STEADY2 = 3'h5;
  localparam logic [2:0] LVL_STEADY3 = 3'h6;
  localparam logic [2:0] LVL_STEADY4 = 3'h7;

  // Steady limit select encodings
  localparam logic [1:0] STEADY_SEL_DEF = 2'h0;
  localparam logic [1:0] STEADY_SEL_L1 = 2'h1;
  localparam logic [1:0] STEADY_SEL_L3 = 2'h2;

  // Times in microseconds and their cycle counts
  localparam int RETRY_PERIOD_US = 150;
  localparam int HID_STEP_US = 1000;
  localparam int BULB55_STEP_US = 500;
  localparam int BULB28_STEP_US = 250;
  localparam logic [CNT_W-1:0] RETRY_CYCLES =
    CNT_W'(RETRY_PERIOD_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] HID_STEP_CYCLES =
    CNT_W'(HID_STEP_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] BULB55_STEP_CYCLES =
    CNT_W'(BULB55_STEP_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] BULB28_STEP_CYCLES =
    CNT_W'(BULB28_STEP_US * CLK_MHZ);

  // Cooling emulation: off time unit is 2**(COOL_SHIFT + slope) cycles
  localparam int COOL_SHIFT = 14;

  localparam logic [4:0] MAX_RETRIES = 5'h10;
  localparam logic [4:0] RETRY_CNT_RST = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [3:0] CH_RST = 4'h0;
endpackage

// file: verilog/qsfp_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
// Assumes one clock; the first stage feeds only the second.
`timescale 1ns/100ps
module qsfp_sync #(
  parameter int WIDTH = 1
) (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else if (ce_in) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// file: verilog/qsfp_protect.sv
// Per-output fault protection, fault latching, status and autoretry.
// Assumes comparator and supply levels from pins; config from same-clock SPI.
`timescale 1ns/100ps
module qsfp_protect #(
  parameter logic [23:0] RETRY_CYCLES = qsfp_pkg::RETRY_CYCLES,
  parameter logic [23:0] HID_STEP_CYCLES = qsfp_pkg::HID_STEP_CYCLES,
  parameter logic [23:0] BULB55_STEP_CYCLES = qsfp_pkg::BULB55_STEP_CYCLES,
  parameter logic [23:0] BULB28_STEP_CYCLES = qsfp_pkg::BULB28_STEP_CYCLES
) (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // Analog comparators and supply monitors (asynchronous)
  input wire logic [3:0] overtemp_in,
  input wire logic [3:0] severe_short_in,
  input wire logic [31:0] overcurrent_cmp_in,
  input wire logic overvoltage_high_in,
  input wire logic overvoltage_low_in,
  input wire logic undervoltage_in,
  input wire logic logic_supply_fail_in,
  input wire logic supply_por_in,
  input wire logic extended_mode_in,
  // Pins (asynchronous)
  input wire logic [3:0] direct_in,
  input wire logic reset_pin_n_in,
  // Control from SPI and PWM logic (same clock)
  input wire logic [3:0] direct_disable_in,
  input wire logic [3:0] on_bit_in,
  input wire logic pwm_enable_in,
  input wire logic [3:0] pwm_duty_in,
  input wire logic fail_safe_in,
  input wire logic [3:0] bulb_mode_in,
  input wire logic [3:0] bulb_28w_in,
  input wire logic [1:0] slope_select_in,
  input wire logic skip_high_step_in,
  input wire logic [1:0] steady_limit_select_in,
  input wire logic cooling_emulation_enable_in,
  input wire logic [1:0] cooling_slope_select_in,
  input wire logic overvoltage_protect_disable_in,
  input wire logic status_read_in,
  // Outputs and status
  output logic [3:0] output_enable_out,
  output logic fault_flag_n_out,
  output logic [3:0] overtemp_status_out,
  output logic [3:0] overcurrent_status_out,
  output logic [3:0] short_circuit_status_out,
  output logic overvoltage_status_out,
  output logic undervoltage_status_out,
  output logic [3:0] retry_exhausted_out
);
  localparam int N = qsfp_pkg::NUM_CH;
  localparam int SW = 51;

  logic [SW-1:0] pins_s;
  logic [3:0] ot_s, sc_s, dir_s;
  logic [31:0] ocmp_s;
  logic ovh_s, ovl_s, uv_s, vdd_fail_s, por_s, ext_s, rstpin_s;

  qsfp_sync #(
    .WIDTH(SW)
  ) u_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .async_in({overtemp_in, severe_short_in, overcurrent_cmp_in,
               overvoltage_high_in, overvoltage_low_in, undervoltage_in,
               logic_supply_fail_in, supply_por_in, extended_mode_in,
               direct_in, reset_pin_n_in}),
    .sync_out(pins_s)
  );

  assign {ot_s, sc_s, ocmp_s, ovh_s, ovl_s, uv_s, vdd_fail_s, por_s, ext_s,
          dir_s, rstpin_s} = pins_s;

  logic [3:0] fc_prev_reg;
  logic [3:0] hson_prev_reg;
  logic fail_safe_prev_reg;
  logic [3:0] ot_latch_reg, oc_latch_reg, sc_latch_reg, uv_latch_reg;
  logic [3:0] dflt_reg, inrush_reg;
  logic [23:0] retry_tmr_reg [N];
  logic [4:0] retry_cnt_reg [N];
  logic [23:0] step_cnt_reg [N];
  logic [23:0] off_cnt_reg [N];
  logic [2:0] lvl_reg [N];
  logic ov_off_reg;

  logic [3:0] hson, fc, fc_rise, hson_rise, retry_req, retry_due;
  logic [3:0] release_ok, latched, oc_trip, warm_start, cold_start;
  logic [2:0] start_lvl [N];
  logic [23:0] step_len [N];
  logic [2:0] steady_lvl [N];
  logic supply_clear, mode_change, ov_en, uv_cut, cooling_ok;

  function automatic logic [2:0] steady_of(input logic [1:0] sel);
    case (sel)
      qsfp_pkg::STEADY_SEL_DEF: steady_of = qsfp_pkg::LVL_STEADY2;
      qsfp_pkg::STEADY_SEL_L1: steady_of = qsfp_pkg::LVL_STEADY1;
      qsfp_pkg::STEADY_SEL_L3: steady_of = qsfp_pkg::LVL_STEADY3;
      default: steady_of = qsfp_pkg::LVL_STEADY4;
    endcase
  endfunction

  // Supply-loss conditions act as a reset of all fault latches and status, but not of the overvoltage shutdown
  assign supply_clear = por_s | (vdd_fail_s & ~uv_s); // RL20
  assign mode_change = fail_safe_in != fail_safe_prev_reg;
  assign ov_en = fail_safe_in ? rstpin_s :
                 ~overvoltage_protect_disable_in; // RL15
  assign uv_cut = uv_s & ~ext_s; // RL19
  assign cooling_ok = cooling_emulation_enable_in & pwm_enable_in &
                      ~fail_safe_in;
  assign latched = ot_latch_reg | oc_latch_reg | sc_latch_reg | uv_latch_reg;

  always_comb begin
    for (int c = 0; c < N; c++) begin
      hson[c] = (((dir_s[c] & ~direct_disable_in[c]) | on_bit_in[c]) &
                 ~pwm_enable_in) |
                (on_bit_in[c] & pwm_duty_in[c] & pwm_enable_in);
      fc[c] = (dir_s[c] & ~direct_disable_in[c] & ~pwm_enable_in) |
              on_bit_in[c]; // RL23
      fc_rise[c] = fc[c] & ~fc_prev_reg[c];
      hson_rise[c] = hson[c] & ~hson_prev_reg[c];
      retry_req[c] = oc_latch_reg[c] | ot_latch_reg[c] |
                     uv_latch_reg[c]; // RL21
      retry_due[c] = retry_req[c] & ~sc_latch_reg[c] &
                     (retry_cnt_reg[c] < qsfp_pkg::MAX_RETRIES) &
                     (retry_tmr_reg[c] == RETRY_CYCLES - 24'h1); // RL22 RL24
      release_ok[c] = ~ot_s[c] & ~uv_s & (fc_rise[c] | retry_due[c]); // RL2
      oc_trip[c] = ocmp_s[c * 8 + int'(lvl_reg[c])] & output_enable_out[c] &
                   ~ext_s; // RL9
      cold_start[c] = fc_rise[c] | retry_due[c]; // RL6
      warm_start[c] = hson_rise[c] & cooling_ok & bulb_mode_in[c] &
                      ~dflt_reg[c]; // RL11
      steady_lvl[c] = dflt_reg[c] ? qsfp_pkg::LVL_STEADY2 :
                      steady_of(steady_limit_select_in); // RL8
      step_len[c] = bulb_mode_in[c] ?
                    (bulb_28w_in[c] ? BULB28_STEP_CYCLES : BULB55_STEP_CYCLES)
                    : HID_STEP_CYCLES; // RL5
      if (!dflt_reg[c]) begin
        step_len[c] = step_len[c] << slope_select_in; // RL7
      end
      start_lvl[c] = (skip_high_step_in & ~dflt_reg[c]) ?
                     qsfp_pkg::LVL_HIGH1 + 3'h1 : qsfp_pkg::LVL_HIGH1; // RL7
      if (warm_start[c] && !cold_start[c]) begin
        // Short off time leaves the filament warm, so start at a lower step
        case (off_cnt_reg[c] >> (qsfp_pkg::COOL_SHIFT +
                                 int'(cooling_slope_select_in)))
          24'h0: start_lvl[c] = qsfp_pkg::LVL_INRUSH_LAST;
          24'h1: start_lvl[c] = qsfp_pkg::LVL_INRUSH_LAST - 3'h1;
          24'h2: start_lvl[c] = qsfp_pkg::LVL_INRUSH_LAST - 3'h2;
          default: start_lvl[c] = qsfp_pkg::LVL_HIGH1;
        endcase
      end
    end
  end

  // Edge history for the turn-on command and the mode
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      fc_prev_reg <= qsfp_pkg::CH_RST;
      hson_prev_reg <= qsfp_pkg::CH_RST;
      fail_safe_prev_reg <= 1'b0;
    end else if (ce_in) begin
      fc_prev_reg <= fc;
      hson_prev_reg <= hson;
      fail_safe_prev_reg <= fail_safe_in;
    end
  end

  // Fault latches: supply clear or mode change wins; else releases first, so a new fault in the same cycle wins
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ot_latch_reg <= qsfp_pkg::CH_RST;
      oc_latch_reg <= qsfp_pkg::CH_RST;
      sc_latch_reg <= qsfp_pkg::CH_RST;
      uv_latch_reg <= qsfp_pkg::CH_RST;
    end else if (ce_in) begin
      if (supply_clear || mode_change) begin
        ot_latch_reg <= qsfp_pkg::CH_RST; // RL20
        oc_latch_reg <= qsfp_pkg::CH_RST;
        sc_latch_reg <= qsfp_pkg::CH_RST;
        uv_latch_reg <= qsfp_pkg::CH_RST;
      end else begin
        for (int c = 0; c < N; c++) begin
          if (release_ok[c]) begin
            ot_latch_reg[c] <= 1'b0; // RL2
            oc_latch_reg[c] <= 1'b0; // RL9
            uv_latch_reg[c] <= 1'b0; // RL18
          end
          if (fc_rise[c] && !sc_s[c]) begin
            sc_latch_reg[c] <= 1'b0; // RL12
          end
          if (ot_s[c] && hson[c]) begin
            ot_latch_reg[c] <= 1'b1; // RL1 RL19
          end
          if (oc_trip[c]) begin
            oc_latch_reg[c] <= 1'b1; // RL9
          end
          if (sc_s[c] && hson[c] && !ext_s) begin
            sc_latch_reg[c] <= 1'b1; // RL12
          end
          if (uv_cut && hson[c]) begin
            uv_latch_reg[c] <= 1'b1; // RL16 RL18
          end
        end
      end
    end
  end

  // Autoretry timer and occurrence counter per channel
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (int c = 0; c < N; c++) begin
        retry_tmr_reg[c] <= qsfp_pkg::CNT_RST;
        retry_cnt_reg[c] <= qsfp_pkg::RETRY_CNT_RST;
      end
      dflt_reg <= qsfp_pkg::CH_RST;
    end else if (ce_in) begin
      for (int c = 0; c < N; c++) begin
        if (supply_clear || mode_change) begin
          retry_tmr_reg[c] <= qsfp_pkg::CNT_RST; // RL22
          retry_cnt_reg[c] <= qsfp_pkg::RETRY_CNT_RST; // RL22
          dflt_reg[c] <= 1'b0;
        end else begin
          if (!retry_req[c] || retry_due[c] ||
              retry_cnt_reg[c] == qsfp_pkg::MAX_RETRIES) begin
            retry_tmr_reg[c] <= qsfp_pkg::CNT_RST; // RL24
          end else begin
            retry_tmr_reg[c] <= retry_tmr_reg[c] + 24'h1;
          end
          if (retry_due[c]) begin
            retry_cnt_reg[c] <= retry_cnt_reg[c] + 5'h1; // RL22
            dflt_reg[c] <= 1'b1; // RL22
          end else if (fc_rise[c]) begin
            dflt_reg[c] <= 1'b0;
          end
        end
      end
    end
  end

  // Overcurrent profile stepping and off-time measurement
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      for (int c = 0; c < N; c++) begin
        lvl_reg[c] <= qsfp_pkg::LVL_STEADY2;
        step_cnt_reg[c] <= qsfp_pkg::CNT_RST;
        off_cnt_reg[c] <= qsfp_pkg::CNT_RST;
      end
      inrush_reg <= qsfp_pkg::CH_RST;
    end else if (ce_in) begin
      for (int c = 0; c < N; c++) begin
        if (hson[c]) begin
          off_cnt_reg[c] <= qsfp_pkg::CNT_RST;
        end else if (off_cnt_reg[c] != 24'hffffff) begin
          off_cnt_reg[c] <= off_cnt_reg[c] + 24'h1; // RL11
        end
        if (cold_start[c] || warm_start[c]) begin
          inrush_reg[c] <= 1'b1; // RL6
          lvl_reg[c] <= start_lvl[c];
          step_cnt_reg[c] <= qsfp_pkg::CNT_RST;
        end else if (inrush_reg[c]) begin
          if (step_cnt_reg[c] >= step_len[c] - 24'h1) begin
            step_cnt_reg[c] <= qsfp_pkg::CNT_RST;
            if (lvl_reg[c] >= qsfp_pkg::LVL_INRUSH_LAST) begin
              inrush_reg[c] <= 1'b0;
              lvl_reg[c] <= steady_lvl[c]; // RL8
            end else begin
              lvl_reg[c] <= lvl_reg[c] + 3'h1; // RL7
            end
          end else begin
            step_cnt_reg[c] <= step_cnt_reg[c] + 24'h1;
          end
        end else begin
          lvl_reg[c] <= steady_lvl[c]; // RL8
        end
      end
    end
  end

  // Overvoltage shutdown holds until the low comparator shows hysteresis or protection is disabled
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ov_off_reg <= 1'b0;
    end else if (ce_in) begin
      if (ovh_s && ov_en) begin
        ov_off_reg <= 1'b1; // RL13
      end else if (!ov_en || ovl_s) begin
        ov_off_reg <= 1'b0; // RL13 RL14
      end
    end
  end

  // Status bits: a read clears, but a fault still present sets again
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      overtemp_status_out <= qsfp_pkg::CH_RST;
      overcurrent_status_out <= qsfp_pkg::CH_RST;
      short_circuit_status_out <= qsfp_pkg::CH_RST;
      overvoltage_status_out <= 1'b0;
      undervoltage_status_out <= 1'b0;
    end else if (ce_in) begin
      if (supply_clear) begin
        overtemp_status_out <= qsfp_pkg::CH_RST; // RL20
        overcurrent_status_out <= qsfp_pkg::CH_RST;
        short_circuit_status_out <= qsfp_pkg::CH_RST;
        overvoltage_status_out <= 1'b0;
        undervoltage_status_out <= 1'b0;
      end else begin
        overtemp_status_out <= (status_read_in ? qsfp_pkg::CH_RST :
                               overtemp_status_out) | ot_s; // RL4 RL19
        overcurrent_status_out <= (status_read_in ? qsfp_pkg::CH_RST :
                                  overcurrent_status_out) | oc_trip; // RL10
        short_circuit_status_out <= (status_read_in ? qsfp_pkg::CH_RST :
                                    short_circuit_status_out) |
                                    (sc_s & hson & {N{~ext_s}}); // RL12
        overvoltage_status_out <= (overvoltage_status_out &
                                  ~status_read_in) | ovh_s; // RL13 RL14
        undervoltage_status_out <= (undervoltage_status_out &
                                   ~status_read_in) | uv_s; // RL16 RL17
      end
    end
  end

  // Output drive and fault pin
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      output_enable_out <= qsfp_pkg::CH_RST;
      fault_flag_n_out <= 1'b1;
      retry_exhausted_out <= qsfp_pkg::CH_RST;
    end else if (ce_in) begin
      for (int c = 0; c < N; c++) begin
        output_enable_out[c] <= hson[c] & ~latched[c] & ~ot_s[c] &
                                ~(sc_s[c] & ~ext_s) & ~ov_off_reg &
                                ~uv_cut & ~oc_trip[c] &
                                ~supply_clear; // RL1 RL9 RL13 RL16 RL19
        retry_exhausted_out[c] <= !supply_clear && !mode_change &&
          retry_cnt_reg[c] == qsfp_pkg::MAX_RETRIES; // RL24
      end
      // Pin goes high again on undervoltage recovery only if nothing latched
      fault_flag_n_out <= ~(|latched | |(ot_s & ~hson) | ov_off_reg |
                           uv_cut); // RL1 RL3 RL12 RL13 RL17 RL18
    end
  end
endmodule

// file: verif/qsfp_protect_chk.sv
// Port-level checker for the switch protection block.
// Assumes ce_in high; pins judged after three stable edges (sync + register), four for the overvoltage shutdown check.
`timescale 1ns/100ps
module qsfp_protect_chk (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Watched inputs
  input wire logic [3:0] overtemp_in,
  input wire logic [3:0] severe_short_in,
  input wire logic [31:0] overcurrent_cmp_in,
  input wire logic overvoltage_high_in,
  input wire logic undervoltage_in,
  input wire logic supply_por_in,
  input wire logic extended_mode_in,
  input wire logic fail_safe_in,
  input wire logic overvoltage_protect_disable_in,
  input wire logic status_read_in,
  // Watched outputs
  input wire logic [3:0] output_enable_out,
  input wire logic fault_flag_n_out,
  input wire logic [3:0] overtemp_status_out,
  input wire logic [3:0] overcurrent_status_out,
  input wire logic [3:0] short_circuit_status_out,
  input wire logic overvoltage_status_out,
  input wire logic undervoltage_status_out,
  input wire logic [3:0] retry_exhausted_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  ot_latch_a: assert property (
    overtemp_in[0] [*3] |=> !output_enable_out[0])
    else $error("hot output stayed on");
  ot_status_a: assert property (
    overtemp_in[1] [*3] |=> overtemp_status_out[1])
    else $error("overheat status not set");
  oc_clear_a: assert property (
    (overcurrent_cmp_in == 32'h0) [*3] ##0 status_read_in
    |=> overcurrent_status_out == 4'h0)
    else $error("overcurrent status survived read");
  sc_latch_a: assert property (
    (severe_short_in[2] && !extended_mode_in) [*3]
    |=> short_circuit_status_out[2] && !output_enable_out[2])
    else $error("short not latched");
  ov_shut_a: assert property (
    (overvoltage_high_in && !overvoltage_protect_disable_in &&
     !fail_safe_in) [*4]
    |=> output_enable_out == 4'h0 && !fault_flag_n_out)
    else $error("overvoltage left outputs on");
  ov_warn_a: assert property (
    overvoltage_high_in [*3] |=> overvoltage_status_out)
    else $error("overvoltage not reported");
  uv_shut_a: assert property (
    (undervoltage_in && !extended_mode_in) [*3]
    |=> output_enable_out == 4'h0 && !fault_flag_n_out &&
        undervoltage_status_out)
    else $error("undervoltage not handled");
  por_clear_a: assert property (
    (supply_por_in && severe_short_in == 4'h0) [*3]
    |=> short_circuit_status_out == 4'h0 && retry_exhausted_out == 4'h0)
    else $error("supply reset kept faults");
endmodule

bind qsfp_protect qsfp_protect_chk chk_u (.clock_in, .sys_rst_in,
  .overtemp_in, .severe_short_in, .overcurrent_cmp_in,
  .overvoltage_high_in, .undervoltage_in, .supply_por_in,
  .extended_mode_in, .fail_safe_in, .overvoltage_protect_disable_in,
  .status_read_in, .output_enable_out, .fault_flag_n_out,
  .overtemp_status_out, .overcurrent_status_out,
  .short_circuit_status_out, .overvoltage_status_out,
  .undervoltage_status_out, .retry_exhausted_out);

// file: verif/qsfp_host.sv
// Host model: turns a bench request into one status read strobe.
// Assumes requests last one cycle on the block's clock.
`timescale 1ns/100ps
module qsfp_host (
  // Clock
  input wire logic clock_in,
  // Bench request and strobe to the block
  input wire logic read_req_in,
  output logic status_read_out
);
  initial status_read_out = 1'b0;
  // Registered, so the strobe is the request delayed by one cycle
  always @(posedge clock_in) begin
    status_read_out <= read_req_in;
  end
endmodule

// file: verif/qsfp_protect_tb_top.sv
// Bench for the switch protection block: pin stimulus and status reads.
// Assumes shortened step and retry counts set at the instance.
`timescale 1ns/100ps
module qsfp_protect_tb_top;
  localparam int RETRY = 20;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] ot = 4'h0, ss = 4'h0, din = 4'h0, ddis = 4'h0, onb = 4'h0;
  logic [31:0] occ = 32'h0;
  logic ovh = 1'b0, ovl = 1'b1, uv = 1'b0, lsf = 1'b0, por = 1'b0;
  logic rstn = 1'b1, fs = 1'b0, skip = 1'b0, ovd = 1'b0, rreq = 1'b0;
  logic [1:0] slope = 2'h0, steady = 2'h0;
  logic ce = 1'b1, ext = 1'b0, pwm = 1'b0, cool = 1'b0;
  logic [3:0] duty = 4'h0, bulb = 4'h8, b28 = 4'h8;
  logic [1:0] cslope = 2'h0;
  logic rd, flag_n, ovs, uvs;
  logic [3:0] oe, ots, ocs, scs, rex;
  logic [2:0] idx [4] = '{3'h5, 3'h4, 3'h6, 3'h7};
  int failures = 0;
  int n_tests = 0;

  always #5 clock_in = ~clock_in;

  qsfp_host host_u (.clock_in(clock_in), .read_req_in(rreq),
    .status_read_out(rd));

  qsfp_protect #(.RETRY_CYCLES(24'h000014), .HID_STEP_CYCLES(24'h000008),
    .BULB55_STEP_CYCLES(24'h000006), .BULB28_STEP_CYCLES(24'h000004)
  ) dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .ce_in(ce),
    .overtemp_in(ot), .severe_short_in(ss), .overcurrent_cmp_in(occ),
    .overvoltage_high_in(ovh), .overvoltage_low_in(ovl),
    .undervoltage_in(uv), .logic_supply_fail_in(lsf), .supply_por_in(por),
    .extended_mode_in(ext), .direct_in(din), .reset_pin_n_in(rstn),
    .direct_disable_in(ddis), .on_bit_in(onb), .pwm_enable_in(pwm),
    .pwm_duty_in(duty), .fail_safe_in(fs), .bulb_mode_in(bulb),
    .bulb_28w_in(b28), .slope_select_in(slope),
    .skip_high_step_in(skip), .steady_limit_select_in(steady),
    .cooling_emulation_enable_in(cool), .cooling_slope_select_in(cslope),
    .overvoltage_protect_disable_in(ovd), .status_read_in(rd),
    .output_enable_out(oe), .fault_flag_n_out(flag_n),
    .overtemp_status_out(ots), .overcurrent_status_out(ocs),
    .short_circuit_status_out(scs), .overvoltage_status_out(ovs),
    .undervoltage_status_out(uvs), .retry_exhausted_out(rex));

  // Waking just after the edge keeps checks clear of the design's updates
  task automatic w(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic read_status();
    rreq <= 1'b1;
    w(1);
    rreq <= 1'b0;
    w(2);
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    w(20);
    sys_rst_in <= 1'b0;
    w(2);
    ot <= 4'h3; w(4);
    check({flag_n, ots[0]}, 2'b01);
    ot <= 4'h0; w(4);
    check(flag_n, 1'b1);
    din <= 4'h1; w(4);
    check(oe, 4'h1);
    ot <= 4'h1; w(4);
    check({oe[0], flag_n}, 2'b00);
    ot <= 4'h0; w(4);
    check(oe[0], 1'b0);
    w(RETRY + 10);
    check({oe[0], flag_n}, 2'b11);
    read_status();
    check(ots, 4'h0);
    ot <= 4'h1; w(4);
    ot <= 4'h0; ddis <= 4'h1; w(4);
    onb <= 4'h1; w(4);
    check(oe[0], 1'b1);
    $display("test overheat done");
    occ <= 32'h0000ff00; din[1] <= 1'b1;
    for (int i = 0; i < 2000 && rex[1] !== 1'b1; i++) w(1);
    if (rex[1] !== 1'b1) begin
      failures++;
      complete_run();
    end
    w(2);
    check({oe[1], ocs[1]}, 2'b01);
    occ <= 32'h0; w(RETRY + 20);
    check(oe[1], 1'b0);
    read_status();
    check(ocs, 4'h0);
    fs <= 1'b1; w(3);
    check({rex[1], oe[1]}, 2'b01);
    fs <= 1'b0; w(3);
    $display("test retry done");
    skip <= 1'b1; slope <= 2'h1; occ <= 32'h01000000; din[3] <= 1'b1;
    w(60);
    check(oe[3], 1'b1);
    din[3] <= 1'b0; skip <= 1'b0; slope <= 2'h0; w(2);
    din[3] <= 1'b1; w(6);
    check(oe[3], 1'b0);
    occ <= 32'h0; w(RETRY + 10);
    for (int s = 0; s < 4; s++) begin
      steady <= 2'(s); din[2] <= 1'b1; w(50);
      occ <= 32'h1 << (16 + idx[(s + 1) % 4]); w(6);
      check(oe[2], 1'b1);
      occ <= 32'h1 << (16 + idx[s]); w(6);
      check(oe[2], 1'b0);
      occ <= 32'h0; din[2] <= 1'b0; w(4);
    end
    steady <= 2'h0; din[2] <= 1'b1; w(4);
    $display("test profile done");
    for (int i = 0; i < 3; i++) begin
      ss <= 4'h4; w(4);
      check({scs[2], oe[2]}, 2'b10);
      ss <= 4'h0; w(RETRY + 20);
      check(oe[2], 1'b0);
      if (i == 0) por <= 1'b1;
      else if (i == 1) lsf <= 1'b1;
      else din[2] <= 1'b0;
      w(5);
      por <= 1'b0; lsf <= 1'b0; din[2] <= 1'b1; w(5);
      check({scs[2] & (i != 2), oe[2]}, 2'b01);
    end
    read_status();
    check(scs, 4'h0);
    $display("test short done");
    din <= 4'hf; w(4);
    ovh <= 1'b1; ovl <= 1'b0; w(4);
    check({oe, flag_n, ovs}, 6'h01);
    ovh <= 1'b0; w(4);
    check(oe, 4'h0);
    ovl <= 1'b1; w(4);
    check(oe, 4'hf);
    read_status();
    check(ovs, 1'b0);
    ovd <= 1'b1; ovh <= 1'b1; ovl <= 1'b0; w(4);
    read_status();
    check({oe, ovs}, 5'h1f);
    ovh <= 1'b0; ovl <= 1'b1; w(4);
    read_status();
    check(ovs, 1'b0);
    ovd <= 1'b0; fs <= 1'b1; rstn <= 1'b0; ovh <= 1'b1; ovl <= 1'b0; w(4);
    check(oe, 4'hf);
    rstn <= 1'b1; w(4);
    check(oe, 4'h0);
    ovh <= 1'b0; ovl <= 1'b1; fs <= 1'b0; w(6);
    $display("test overvoltage done");
    din <= 4'h8; w(4);
    uv <= 1'b1; w(4);
    check({oe, flag_n, uvs}, 6'h01);
    uv <= 1'b0; w(4);
    check(flag_n, 1'b0);
    w(RETRY + 10);
    check({oe[3], flag_n}, 2'b11);
    din <= 4'h0; onb <= 4'h0; w(2);
    uv <= 1'b1; w(4);
    uv <= 1'b0; w(4);
    check({flag_n, uvs}, 2'b11);
    read_status();
    check(uvs, 1'b0);
    ext <= 1'b1; din <= 4'h8; w(4);
    uv <= 1'b1; w(4);
    check({oe[3], flag_n}, 2'b11);
    uv <= 1'b0; ext <= 1'b0; ce <= 1'b0; din <= 4'h0; w(6);
    check(oe[3], 1'b1);
    ce <= 1'b1; w(4);
    check(oe[3], 1'b0);
    $display("test undervoltage done");
    pwm <= 1'b1; cool <= 1'b1; cslope <= 2'h3; b28 <= 4'h0;
    duty <= 4'h8; onb <= 4'h8; w(40);
    check(oe[3], 1'b1);
    duty <= 4'h0; occ <= 32'h08000000; w(4);
    duty <= 4'h8; w(4);
    check(oe[3], 1'b0);
    $display("test cooling done");
    complete_run();
  end
endmodule
